// ===== design/serial_port_cfg.svh
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH

// ----------------------------------------
// Word and header layout
// ----------------------------------------
`define WORD_W          24
`define HDR_BITS        5'h05
`define MIN_WRITE_BITS  5'h04
`define FULL_WORD_BITS  5'h18
`define ADDR_LO         4'h1
`define ADDR_HI         4'h7
`define PWR_ADDR        4'h5
`define AUDIO_ADDR      4'h6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RO_LSB          12
`define BATT_MSB        23
`define BATT_LSB        18
`define SIGNAL_STRENGTH_LEVEL_MSB        17
`define SIGNAL_STRENGTH_LEVEL_LSB        12
`define REF_OSC_BIT     0
`define TX_PLL_BIT      1
`define RX_PLL_BIT      2
`define LO2_BIT         3
`define SPKR_BIT        4
`define RX_AUDIO_BIT    5
`define TX_AUDIO_BIT    6
`define ADC_BIT         7
`define SLICER_BIT      8
`define MCU_CLK_BIT     7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TX_DIV_RESET    24'h080040
`define OTHER_RESET     24'h000000

`endif

// ===== design/serial_port_pkg.sv
package serial_port_pkg;

  typedef logic [23:0] word_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HEADER,
    ST_WRITE,
    ST_READ,
    ST_END
  } port_state_type;

endpackage

// ===== design/pin_events_if.sv
interface pin_events_if;
  logic sclk_rise;
  logic en_rise;
  logic en_fall;
  logic data_level;

  modport syncer (
    output sclk_rise,
    output en_rise,
    output en_fall,
    output data_level
  );

  modport engine (
    input sclk_rise,
    input en_rise,
    input en_fall,
    input data_level
  );
endinterface

// ===== design/pin_sync.sv
module pin_sync (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Raw pins: 0 serial clock, 1 enable, 2 data
  input  wire logic [2:0] pins_raw,
  // Filtered events
  pin_events_if.syncer    ev
);

  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] level_reg;
  logic [2:0] rise_reg;
  logic [2:0] fall_reg;

  // ----------------------------------------
  // Three-stage sampling, change taken when stages two and three agree
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_pin
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          s1_reg[i]    <= 1'b0;
          s2_reg[i]    <= 1'b0;
          s3_reg[i]    <= 1'b0;
          level_reg[i] <= 1'b0;
          rise_reg[i]  <= 1'b0;
          fall_reg[i]  <= 1'b0;
        end else begin
          s1_reg[i]    <= pins_raw[i];
          s2_reg[i]    <= s1_reg[i];
          s3_reg[i]    <= s2_reg[i];
          rise_reg[i]  <= (s2_reg[i] == s3_reg[i]) && s2_reg[i] && !level_reg[i];
          fall_reg[i]  <= (s2_reg[i] == s3_reg[i]) && !s2_reg[i] && level_reg[i];
          if (s2_reg[i] == s3_reg[i]) begin
            level_reg[i] <= s2_reg[i];
          end
        end
      end
    end
  endgenerate

  assign ev.sclk_rise  = rise_reg[0];
  assign ev.en_rise    = rise_reg[1];
  assign ev.en_fall    = fall_reg[1];
  assign ev.data_level = level_reg[2];

endmodule

// ===== design/serial_port.sv
// How it works
// - Four address bits follow, MSB first; only addresses one to seven are valid.
// - Enable falling after header latches address and loads 24-bit output shifter.
// - First serial clock rise with enable low turns data pin to output, MSB.
// - Twenty-four rising edges shift the word out MSB first, LSB last.
// - Enable pulse after last bit; its falling edge returns data pin to input.
// - Register five read returns measurement bits in positions 23 down to 12.
// - Each power-down bit disables its section when one, enables when zero.
// - Register five bit zero stops the reference oscillator; other variant ignores it.
// - Register five bit one disables the transmit PLL.
// - Register five bit two disables the receive PLL.
// - Register five bit three disables the second local oscillator loop.
// - Register five bit four disables both speaker amplifiers.
// - Bit five disables receive audio; bit six disables transmit audio.
// - Register five bit seven disables both measurement converters.
// - Register five bit eight disables the data slicer, floating its output.
// - Register six bit seven disables microcontroller clock output; variant keeps it running.
// - Reference counter is off whenever all three PLL disable bits are set.
// - Every serial bit moves on the rising serial clock edge.
// - Header starting with zero is a write; enable pulse latches the data.
// - Register five bits 23 to 12 are read-only; others read and write.
`include "serial_port_cfg.svh"

module serial_port #(
  parameter bit HAS_GATING_OPTIONS = 1'b1
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // Serial port pins
  input  wire logic        SCLK,
  input  wire logic        ENABLE,
  input  wire logic        DATA_IN,
  output logic             DATA_OUT,
  output logic             DATA_OE_N,
  // Measurement results
  input  wire logic [5:0]  BATTERY_LEVEL,
  input  wire logic [5:0]  SIGNAL_STRENGTH_LEVEL,
  // Register contents for the analog sections
  output logic [23:0]      TX_SYNTH_DIVIDER,
  output logic [23:0]      RX_SYNTH_DIVIDER,
  output logic [23:0]      SECOND_OSC_DIVIDER,
  output logic [23:0]      REFERENCE_AND_FILTER_DIVIDER,
  output logic [11:0]      POWER_DOWN_CONTROL,
  output logic [23:0]      AUDIO_PATH_CONTROL,
  output logic [23:0]      GAIN_AND_VOLUME,
  // Section disables, high turns the section off
  output logic             REF_OSC_OFF,
  output logic             TX_PLL_OFF,
  output logic             RX_PLL_OFF,
  output logic             SECOND_LOCAL_OSC_OFF,
  output logic             SPEAKER_AMP_OFF,
  output logic             RX_AUDIO_OFF,
  output logic             TX_AUDIO_OFF,
  output logic             LEVEL_ADC_OFF,
  output logic             SLICER_OFF,
  output logic             MCU_CLOCK_OFF,
  output logic             REF_COUNTER_OFF
);

  // ----------------------------------------
  // Pin conditioning
  // ----------------------------------------
  pin_events_if ev ();

  pin_sync u_sync (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .pins_raw ({DATA_IN, ENABLE, SCLK}),
    .ev       (ev.syncer)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  serial_port_pkg::port_state_type state_reg;
  serial_port_pkg::word_type       regs_reg [1:7];
  serial_port_pkg::word_type       out_shift_reg;
  serial_port_pkg::word_type       in_shift_reg;
  serial_port_pkg::word_type       write_next;
  logic [4:0]                      hdr_reg;
  logic [4:0]                      count_reg;
  logic                            is_read_reg;
  logic [3:0]                      addr_reg;
  logic                            oe_n_reg;
  logic [11:0]                     pwr_next;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // address range check
  function automatic logic addr_valid(input logic [3:0] a);
    addr_valid = (a >= `ADDR_LO) && (a <= `ADDR_HI);
  endfunction

  function automatic serial_port_pkg::word_type low_mask(input logic [4:0] n);
    serial_port_pkg::word_type m;
    m = '0;
    for (int k = 0; k < `WORD_W; k++) begin
      if (k < int'(n)) begin
        m[k] = 1'b1;
      end
    end
    low_mask = m;
  endfunction

  function automatic serial_port_pkg::word_type read_word(
    input logic [3:0]               a,
    input serial_port_pkg::word_type r5,
    input serial_port_pkg::word_type rv
  );
    if (!addr_valid(a)) begin
      read_word = '0;
    end else if (a == `PWR_ADDR) begin
      read_word = {BATTERY_LEVEL, SIGNAL_STRENGTH_LEVEL, r5[`RO_LSB-1:0]};
    end else begin
      read_word = rv;
    end
  endfunction

  // Entered bits replace only the low-order bits that were clocked in
  always_comb begin
    write_next = (regs_reg[addr_reg[2:0]] & ~low_mask(count_reg))
               | (in_shift_reg & low_mask(count_reg));
    if (addr_reg == `PWR_ADDR) begin
      write_next[`WORD_W-1:`RO_LSB] = regs_reg[5][`WORD_W-1:`RO_LSB];
    end
  end

  // ----------------------------------------
  // Transfer sequencing
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_reg   <= serial_port_pkg::ST_IDLE;
      hdr_reg     <= 5'h00;
      count_reg   <= 5'h00;
      is_read_reg <= 1'b0;
      addr_reg    <= 4'h0;
    end else begin
      unique case (state_reg)
        serial_port_pkg::ST_IDLE: begin
          if (ev.en_rise) begin
            state_reg <= serial_port_pkg::ST_HEADER;
            count_reg <= 5'h00;
          end
        end
        serial_port_pkg::ST_HEADER: begin
          // header bits taken on clock rise
          if (ev.sclk_rise) begin
            hdr_reg <= {hdr_reg[3:0], ev.data_level};
            if (count_reg < `HDR_BITS) begin
              count_reg <= count_reg + 5'h01;
            end
          end
          if (ev.en_fall) begin
            count_reg   <= 5'h00;
            is_read_reg <= hdr_reg[4];
            addr_reg    <= hdr_reg[3:0];
            if (count_reg < `HDR_BITS) begin
              state_reg <= serial_port_pkg::ST_IDLE;
            end else if (hdr_reg[4]) begin
              state_reg <= serial_port_pkg::ST_READ;
            end else begin
              state_reg <= serial_port_pkg::ST_WRITE;
            end
          end
        end
        serial_port_pkg::ST_WRITE, serial_port_pkg::ST_READ: begin
          if (ev.sclk_rise && count_reg < `FULL_WORD_BITS) begin
            count_reg <= count_reg + 5'h01;
          end
          if (ev.en_rise) begin
            state_reg <= serial_port_pkg::ST_END;
          end
        end
        serial_port_pkg::ST_END: begin
          if (ev.en_fall) begin
            state_reg <= serial_port_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Write data shifter
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      in_shift_reg <= '0;
    end else if (state_reg == serial_port_pkg::ST_HEADER) begin
      in_shift_reg <= '0;
    end else if (state_reg == serial_port_pkg::ST_WRITE && ev.sclk_rise) begin
      // data bits taken on clock rise
      in_shift_reg <= {in_shift_reg[`WORD_W-2:0], ev.data_level};
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      regs_reg[1] <= `TX_DIV_RESET;
      for (int k = 2; k <= 7; k++) begin
        regs_reg[k] <= `OTHER_RESET;
      end
    end else if (state_reg == serial_port_pkg::ST_END && ev.en_fall && !is_read_reg
                 && addr_valid(addr_reg) && count_reg >= `MIN_WRITE_BITS) begin
      // data latched at the closing enable fall
      regs_reg[addr_reg[2:0]] <= write_next;
    end
  end

  // ----------------------------------------
  // Read shifter and data pin drive
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      out_shift_reg <= '0;
    end else if (state_reg == serial_port_pkg::ST_HEADER && ev.en_fall) begin
      // measurement bits merged for register five
      out_shift_reg <= read_word(hdr_reg[3:0], regs_reg[5], regs_reg[hdr_reg[2:0]]);
    end else if (state_reg == serial_port_pkg::ST_READ && ev.sclk_rise && !oe_n_reg
                 && count_reg < `FULL_WORD_BITS) begin
      // next bit on each later rise, MSB first
      out_shift_reg <= {out_shift_reg[`WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      oe_n_reg <= 1'b1;
    end else if (state_reg == serial_port_pkg::ST_READ && ev.sclk_rise) begin
      // first rise turns pin to output
      oe_n_reg <= 1'b0;
    end else if (state_reg == serial_port_pkg::ST_END && ev.en_fall) begin
      oe_n_reg <= 1'b1;
    end else if (state_reg == serial_port_pkg::ST_IDLE) begin
      oe_n_reg <= 1'b1;
    end
  end

  assign DATA_OUT  = out_shift_reg[`WORD_W-1];
  assign DATA_OE_N = oe_n_reg;

  // ----------------------------------------
  // Register contents out
  // ----------------------------------------
  assign TX_SYNTH_DIVIDER             = regs_reg[1];
  assign RX_SYNTH_DIVIDER             = regs_reg[2];
  assign SECOND_OSC_DIVIDER           = regs_reg[3];
  assign REFERENCE_AND_FILTER_DIVIDER = regs_reg[4];
  assign POWER_DOWN_CONTROL           = regs_reg[5][`RO_LSB-1:0];
  assign AUDIO_PATH_CONTROL           = regs_reg[6];
  assign GAIN_AND_VOLUME              = regs_reg[7];

  // ----------------------------------------
  // Section power gating
  // ----------------------------------------
  assign pwr_next = regs_reg[5][`RO_LSB-1:0];

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      REF_OSC_OFF          <= 1'b0;
      TX_PLL_OFF           <= 1'b0;
      RX_PLL_OFF           <= 1'b0;
      SECOND_LOCAL_OSC_OFF <= 1'b0;
      SPEAKER_AMP_OFF      <= 1'b0;
      RX_AUDIO_OFF         <= 1'b0;
      TX_AUDIO_OFF         <= 1'b0;
      LEVEL_ADC_OFF        <= 1'b0;
      SLICER_OFF           <= 1'b0;
      MCU_CLOCK_OFF        <= 1'b0;
      REF_COUNTER_OFF      <= 1'b0;
    end else begin
      // oscillator stop only on the gated variant
      REF_OSC_OFF          <= HAS_GATING_OPTIONS && pwr_next[`REF_OSC_BIT];
      TX_PLL_OFF           <= pwr_next[`TX_PLL_BIT];
      RX_PLL_OFF           <= pwr_next[`RX_PLL_BIT];
      SECOND_LOCAL_OSC_OFF <= pwr_next[`LO2_BIT];
      SPEAKER_AMP_OFF      <= pwr_next[`SPKR_BIT];
      RX_AUDIO_OFF         <= pwr_next[`RX_AUDIO_BIT];
      TX_AUDIO_OFF         <= pwr_next[`TX_AUDIO_BIT];
      LEVEL_ADC_OFF        <= pwr_next[`ADC_BIT];
      SLICER_OFF           <= pwr_next[`SLICER_BIT];
      // clock output off on the gated variant only
      MCU_CLOCK_OFF        <= HAS_GATING_OPTIONS && regs_reg[6][`MCU_CLK_BIT];
      // reference counter off with all loops off
      REF_COUNTER_OFF      <= pwr_next[`TX_PLL_BIT] && pwr_next[`RX_PLL_BIT]
                              && pwr_next[`LO2_BIT];
    end
  end

endmodule

// ===== bench/serial_port_monitor.sv
module serial_port_monitor #(
  parameter bit HAS_GATING_OPTIONS = 1'b1
) (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESET_N,
  // Serial pins
  input wire logic        SCLK,
  input wire logic        ENABLE,
  input wire logic        DATA_OUT,
  input wire logic        DATA_OE_N,
  // Registers and disables
  input wire logic [11:0] POWER_DOWN_CONTROL,
  input wire logic [23:0] AUDIO_PATH_CONTROL,
  input wire logic        REF_OSC_OFF,
  input wire logic        TX_PLL_OFF,
  input wire logic        RX_PLL_OFF,
  input wire logic        SECOND_LOCAL_OSC_OFF,
  input wire logic        SPEAKER_AMP_OFF,
  input wire logic        RX_AUDIO_OFF,
  input wire logic        TX_AUDIO_OFF,
  input wire logic        LEVEL_ADC_OFF,
  input wire logic        SLICER_OFF,
  input wire logic        MCU_CLOCK_OFF,
  input wire logic        REF_COUNTER_OFF
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       sclk_q;
  logic       en_q;
  logic [3:0] sclk_age;
  logic [3:0] en_age;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // Cycles since a pin edge was sampled, saturating
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sclk_q   <= 1'b0;
      sclk_age <= 4'hf;
    end else begin
      sclk_q <= SCLK;
      if (SCLK && !sclk_q) sclk_age <= 4'h0;
      else if (sclk_age != 4'hf) sclk_age <= sclk_age + 4'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      en_q   <= 1'b0;
      en_age <= 4'hf;
    end else begin
      en_q <= ENABLE;
      if (!ENABLE && en_q) en_age <= 4'h0;
      else if (en_age != 4'hf) en_age <= en_age + 4'h1;
    end
  end

  sequence s_sclk_seen;
    sclk_age inside {[4'h2:4'h6]};
  endsequence

  sequence s_en_fall_seen;
    en_age inside {[4'h2:4'h6]};
  endsequence

  AST_OE_ON: assert property ($fell(DATA_OE_N) |-> s_sclk_seen ##0 !ENABLE)
    else $error("data pin driven without a serial clock rise");
  AST_OE_OFF: assert property ($rose(DATA_OE_N) |-> s_en_fall_seen)
    else $error("data pin released without an enable fall");
  AST_OE_HELD: assert property ($rose(ENABLE) && !DATA_OE_N |-> !DATA_OE_N [*6])
    else $error("data pin released during closing pulse");
  AST_DOUT_SHIFT: assert property (!DATA_OE_N && $past(!DATA_OE_N) && $changed(DATA_OUT)
    |-> s_sclk_seen)
    else $error("read bit changed without a serial clock rise");
  AST_REG_WRITE: assert property ($changed(POWER_DOWN_CONTROL) || $changed(AUDIO_PATH_CONTROL)
    |-> s_en_fall_seen)
    else $error("register changed without an enable fall");
  AST_PD_BITS: assert property ({SLICER_OFF, LEVEL_ADC_OFF, TX_AUDIO_OFF, RX_AUDIO_OFF,
    SPEAKER_AMP_OFF, SECOND_LOCAL_OSC_OFF, RX_PLL_OFF, TX_PLL_OFF}
    == $past(POWER_DOWN_CONTROL[8:1]))
    else $error("section disable differs from register");
  AST_REF_OSC: assert property (REF_OSC_OFF
    == (HAS_GATING_OPTIONS && $past(POWER_DOWN_CONTROL[0])))
    else $error("reference oscillator disable wrong");
  AST_MCU_CLK: assert property (MCU_CLOCK_OFF
    == (HAS_GATING_OPTIONS && $past(AUDIO_PATH_CONTROL[7])))
    else $error("controller clock disable wrong");
  AST_REF_CNT: assert property (REF_COUNTER_OFF == &$past(POWER_DOWN_CONTROL[3:1]))
    else $error("reference counter disable wrong");
endmodule

bind serial_port serial_port_monitor #(.HAS_GATING_OPTIONS(HAS_GATING_OPTIONS)) monitor (
  .CLK(CLK), .RESET_N(RESET_N), .SCLK(SCLK), .ENABLE(ENABLE), .DATA_OUT(DATA_OUT),
  .DATA_OE_N(DATA_OE_N), .POWER_DOWN_CONTROL(POWER_DOWN_CONTROL),
  .AUDIO_PATH_CONTROL(AUDIO_PATH_CONTROL), .REF_OSC_OFF(REF_OSC_OFF),
  .TX_PLL_OFF(TX_PLL_OFF), .RX_PLL_OFF(RX_PLL_OFF),
  .SECOND_LOCAL_OSC_OFF(SECOND_LOCAL_OSC_OFF), .SPEAKER_AMP_OFF(SPEAKER_AMP_OFF),
  .RX_AUDIO_OFF(RX_AUDIO_OFF), .TX_AUDIO_OFF(TX_AUDIO_OFF), .LEVEL_ADC_OFF(LEVEL_ADC_OFF),
  .SLICER_OFF(SLICER_OFF), .MCU_CLOCK_OFF(MCU_CLOCK_OFF), .REF_COUNTER_OFF(REF_COUNTER_OFF)
);

// ===== bench/serial_host.sv
module serial_host (
  // Clock
  input  wire logic clk,
  // Port pins
  output logic      sclk,
  output logic      enable,
  output logic      data_pin,
  // Device drive
  input  wire logic data_out,
  input  wire logic data_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  logic host_bit;

  // Floated line shows the inverse of its last level
  assign data_pin = data_oe_n ? host_bit : data_out;

  initial begin
    sclk = 1'b0;
    enable = 1'b0;
    host_bit = 1'b0;
  end

  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  task automatic init();
    host_bit = ~host_bit;
    sclk = 1'b1;
    half();
    sclk = 1'b0;
    half();
  endtask

  task automatic shift(input int n, input logic [23:0] v, input bit drv,
                       output logic [23:0] got);
    got = 24'h000000;
    host_bit = drv ? v[n-1] : ~host_bit;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      half();
      sclk = 1'b0;
      if (drv && i > 0) host_bit = v[i-1];
      repeat (3) @(negedge clk);
      got[i] = data_pin;
      @(negedge clk);
    end
  endtask

  task automatic xfer(input logic rd, input logic [3:0] addr, input int n,
                      input logic [23:0] wd, output logic [23:0] got);
    logic [23:0] hdr;
    enable = 1'b1;
    half();
    shift(5, {19'h00000, rd, addr}, 1'b1, hdr);
    enable = 1'b0;
    shift(n, wd, !rd, got);
    enable = 1'b1;
    half();
    enable = 1'b0;
    host_bit = ~host_bit;
    half();
  endtask
endmodule

// ===== bench/serial_readback_and_power_gating_bench.sv
module serial_readback_and_power_gating_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk;
  logic        reset_n;
  logic        sclk;
  logic        enable;
  logic        data_pin;
  logic        data_out;
  logic        data_oe_n;
  logic [5:0]  batt;
  logic [5:0]  sig_lvl;
  logic [11:0] pdc;
  logic [10:0] off;
  logic [23:0] tx_div;
  logic [23:0] rx_div;
  logic [23:0] osc_div;
  logic [23:0] ref_div;
  logic [23:0] audio;
  logic [23:0] gain;
  logic [23:0] exp_reg [1:7];
  logic [23:0] got;
  int          failures;
  int          cmp_count;
  int          cycles;
  int          seed;

  serial_port uut (
    .CLK(clk), .RESET_N(reset_n), .SCLK(sclk), .ENABLE(enable), .DATA_IN(data_pin),
    .DATA_OUT(data_out), .DATA_OE_N(data_oe_n), .BATTERY_LEVEL(batt),
    .SIGNAL_STRENGTH_LEVEL(sig_lvl), .TX_SYNTH_DIVIDER(tx_div), .RX_SYNTH_DIVIDER(rx_div),
    .SECOND_OSC_DIVIDER(osc_div), .REFERENCE_AND_FILTER_DIVIDER(ref_div),
    .POWER_DOWN_CONTROL(pdc), .AUDIO_PATH_CONTROL(audio), .GAIN_AND_VOLUME(gain),
    .REF_OSC_OFF(off[0]), .TX_PLL_OFF(off[1]),
    .RX_PLL_OFF(off[2]), .SECOND_LOCAL_OSC_OFF(off[3]), .SPEAKER_AMP_OFF(off[4]),
    .RX_AUDIO_OFF(off[5]), .TX_AUDIO_OFF(off[6]), .LEVEL_ADC_OFF(off[7]),
    .SLICER_OFF(off[8]), .MCU_CLOCK_OFF(off[9]), .REF_COUNTER_OFF(off[10])
  );

  serial_host host (
    .clk(clk), .sclk(sclk), .enable(enable), .data_pin(data_pin),
    .data_out(data_out), .data_oe_n(data_oe_n)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_word(input logic [23:0] g, input logic [23:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t word %h expected %h", $time, g, e);
    end
  endtask

  task automatic check_flag(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t flag %b expected %b", $time, g, e);
    end
  endtask

  function automatic logic [23:0] expect_read(input logic [3:0] a);
    if (a < 4'h1 || a > 4'h7) return 24'h000000;
    if (a == 4'h5) return {batt, sig_lvl, exp_reg[5][11:0]};
    return exp_reg[a[2:0]];
  endfunction

  // Register contents as the device presents them on its outputs
  function automatic logic [23:0] dev_word(input logic [3:0] a);
    case (a)
      4'h1: return tx_div;
      4'h2: return rx_div;
      4'h3: return osc_div;
      4'h4: return ref_div;
      4'h5: return {12'h000, pdc};
      4'h6: return audio;
      4'h7: return gain;
      default: return 24'h000000;
    endcase
  endfunction

  task automatic apply_reset();
    reset_n = 1'b0;
    exp_reg[1] = 24'h080040;
    for (int i = 2; i <= 7; i++) exp_reg[i] = 24'h000000;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    host.init();
  endtask

  task automatic do_read(input logic [3:0] a);
    batt = 6'($urandom);
    sig_lvl = 6'($urandom);
    host.xfer(1'b1, a, 24, 24'h000000, got);
    check_word(got, expect_read(a));
    repeat (2) @(negedge clk);
    check_flag(data_oe_n, 1'b1);
  endtask

  task automatic do_write(input logic [3:0] a, input int n, input logic [23:0] wd);
    logic [23:0] m;
    m = (n >= 24) ? 24'hffffff : 24'((1 << n) - 1);
    host.xfer(1'b0, a, n, wd, got);
    if (a >= 4'h1 && a <= 4'h7 && n >= 4) exp_reg[a[2:0]] = (exp_reg[a[2:0]] & ~m) | (wd & m);
    repeat (2) @(negedge clk);
    check_word(24'(pdc), 24'(exp_reg[5][11:0]));
    check_word(24'(off), 24'({&exp_reg[5][3:1], exp_reg[6][7], exp_reg[5][8:0]}));
    for (int i = 1; i <= 7; i++) if (i != 5) check_word(dev_word(4'(i)), exp_reg[i]);
    do_read(a);
  endtask

  initial begin
    failures = 0;
    cmp_count = 0;
    cycles = 0;
    batt = 6'h00;
    sig_lvl = 6'h00;
    seed = $urandom(32'h0c96);
    apply_reset();
    for (int a = 0; a < 16; a++) do_read(4'(a));
    do_write(4'h5, 24, 24'hffffff);
    do_write(4'h5, 24, 24'h00000e);
    do_write(4'h6, 8, 24'h000080);
    do_write(4'h5, 4, 24'h000001);
    do_write(4'h0, 24, 24'ha5a5a5);
    do_write(4'h9, 24, 24'h5a5a5a);
    do_write(4'h7, 3, 24'h000005);
    repeat (20) do_write(4'($urandom_range(0, 15)), $urandom_range(4, 24), 24'($urandom));
    apply_reset();
    do_read(4'h1);
    do_read(4'h5);
    print_verdict();
  end
endmodule
